/* File: inc/accs_defines.vh */
// Register offsets, field positions, reset values and timing constants.
`ifndef ACCS_DEFINES_VH
`define ACCS_DEFINES_VH
`define ACCS_OFF_CTRL 8'h00
`define ACCS_OFF_TRIG 8'h04
`define ACCS_OFF_SLEEP 8'h08
`define ACCS_OFF_SETTLE 8'h0C
`define ACCS_OFF_STATUS 8'h10
`define ACCS_OFF_CALLEN 8'h14
`define ACCS_CTRL_BG 0
`define ACCS_CTRL_TRIGSEL 1
`define ACCS_CTRL_LP 2
`define ACCS_CTRL_MANUAL 3
`define ACCS_CTRL_STSEL 4
`define ACCS_CTRL_RESET 32'h0000_0000
`define ACCS_SLEEP_RESET 32'h0000_0400
`define ACCS_SETTLE_RESET 32'h0000_0040
`define ACCS_CALLEN_RESET 32'h0000_0100
`define ACCS_MIDCODE 12'h000
`define ACCS_BANKS_ALL 6'h3F
`define ACCS_CORE_A 2'h0
`define ACCS_CORE_B 2'h1
`define ACCS_CORE_C 2'h2
`define ACCS_ST_IDLE 3'h0
`define ACCS_ST_FG 3'h1
`define ACCS_ST_SLEEP 3'h2
`define ACCS_ST_SETTLE 3'h3
`define ACCS_ST_CAL 3'h4
`define ACCS_ST_HOLD 3'h5
`endif

/* File: hw/accs_sequencer.v */
// Calibration sequencer for a three-core, six-bank interleaved converter.
//
// Functional notes
// R01: Foreground calibration forces mid-code output samples.
// R02: Background mode keeps converting without data gaps.
// R03: Six banks paired into three interleaved cores.
// R04: Foreground: core A/B sample inputs per mode.
// R05: Third core periodically substitutes for A and B.
// R06: Calibration trims linearity, gain, offset per bank.
// R07: Foreground calibration runs automatically after power-up.
// R08: Controller waits for power-up calibration before programming.
// R09: Trigger source select picks pin or software trigger.
// R10: Background needs enable, select zero, soft trigger.
// R11: Spare calibrated, swapped in, released core next.
// R12: Low-power keeps spare core powered down.
// R13: Manual bit selects timer or trigger scheme.
// R14: Sleep interval sets spare sleep time.
// R15: Settle interval precedes spare calibration.
// R16: Automatic mode swaps immediately, released core sleeps.
// R17: Manual mode sleeps spare while trigger high.
// R18: Low trigger wakes spare, settles, calibrates.
// R19: Manual swap waits for trigger high again.
// R20: Status select one shows spare calibration finished.
// R21: Pin trigger synchronised before use.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "accs_defines.vh"

module accs_sequencer #(
   parameter DW = 12,
   parameter CW = 32
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire calibration_pin_request,
   input wire single_channel,
   input wire input_b_select,
   input wire [DW-1:0] bank_sample_0,
   input wire [DW-1:0] bank_sample_1,
   input wire [DW-1:0] bank_sample_2,
   input wire [DW-1:0] bank_sample_3,
   input wire [DW-1:0] bank_sample_4,
   input wire [DW-1:0] bank_sample_5,
   input wire bank_phase,
   output reg [DW-1:0] sample_out_a,
   output reg [DW-1:0] sample_out_b,
   output reg [5:0] bank_power,
   output reg [5:0] bank_calibrate,
   output reg [1:0] core_in_use_a,
   output reg [1:0] core_in_use_b,
   output reg core_a_input_b,
   output reg core_b_input_b,
   output reg calibration_status_pin
);

   // ==========================================================
   // Bus slave
   // ==========================================================
   reg [31:0] ctrl_r;
   reg software_calibration_request_r;
   reg [CW-1:0] spare_sleep_interval_r;
   reg [CW-1:0] spare_settle_interval_r;
   reg [CW-1:0] cal_length_r;
   reg wr_pend_r;
   reg [7:0] wr_addr_r;
   reg [31:0] rdata_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [1:0] spare_r;
   reg [1:0] spare_nxt;
   reg next_target_r;
   reg next_target_nxt;
   reg [CW-1:0] cnt_r;
   reg [CW-1:0] cnt_nxt;
   reg fg_done_r;
   reg spare_calibration_finished_r;
   reg sync1_r;
   reg sync2_r;
   reg trig_prev_r;

   wire background_calibration_enable = ctrl_r[`ACCS_CTRL_BG];
   wire trigger_source_select = ctrl_r[`ACCS_CTRL_TRIGSEL];
   wire low_power_spare_enable = ctrl_r[`ACCS_CTRL_LP];
   wire manual_swap_control = ctrl_r[`ACCS_CTRL_MANUAL];
   wire status_select = ctrl_r[`ACCS_CTRL_STSEL];
   wire low_power_background_mode = background_calibration_enable &
      low_power_spare_enable;
   wire take = hsel & hready & htrans[1];

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
      end else begin
         wr_pend_r <= take & hwrite;
         wr_addr_r <= haddr[7:0];
         rdata_r <= 32'h0000_0000;
         if (take & !hwrite) begin
            case (haddr[7:0])
               `ACCS_OFF_CTRL: rdata_r <= ctrl_r;
               `ACCS_OFF_TRIG:
                  rdata_r <= {31'h0000_0000,
                     software_calibration_request_r};
               `ACCS_OFF_SLEEP: rdata_r <= spare_sleep_interval_r;
               `ACCS_OFF_SETTLE: rdata_r <= spare_settle_interval_r;
               `ACCS_OFF_CALLEN: rdata_r <= cal_length_r;
               `ACCS_OFF_STATUS:
                  rdata_r <= {24'h00_0000, spare_r, core_in_use_b,
                     core_in_use_a, spare_calibration_finished_r,
                     fg_done_r};
               default: rdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= `ACCS_CTRL_RESET;
         software_calibration_request_r <= 1'b0;
         spare_sleep_interval_r <= `ACCS_SLEEP_RESET;
         spare_settle_interval_r <= `ACCS_SETTLE_RESET;
         cal_length_r <= `ACCS_CALLEN_RESET;
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            `ACCS_OFF_CTRL: ctrl_r <= {27'h000_0000, hwdata[4:0]};
            `ACCS_OFF_TRIG: software_calibration_request_r <= hwdata[0];
            `ACCS_OFF_SLEEP: spare_sleep_interval_r <= hwdata;
            `ACCS_OFF_SETTLE: spare_settle_interval_r <= hwdata;
            `ACCS_OFF_CALLEN: cal_length_r <= hwdata;
            default: ctrl_r <= ctrl_r;
         endcase
      end
   end

   // ==========================================================
   // Trigger selection
   // ==========================================================
   // Pin when the select bit is set, software bit otherwise.
   wire trig = trigger_source_select ? sync2_r :
      software_calibration_request_r; // R09
   wire trig_rise = trig & !trig_prev_r;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         trig_prev_r <= 1'b0;
      end else begin
         sync1_r <= calibration_pin_request; // R21
         sync2_r <= sync1_r; // R21
         trig_prev_r <= trig;
      end
   end

   // ==========================================================
   // Sequencer
   // ==========================================================
   // State overview.
   // FG runs the foreground calibration, with both sample outputs at mid-code.
   // IDLE waits for a foreground trigger or the background start.
   // SLEEP keeps the spare core powered down in low-power mode, either
   // for the sleep interval or for as long as the trigger stays high.
   // SETTLE gives a freshly woken spare core time to stabilise.
   // CAL calibrates the spare core while two other cores carry data.
   // HOLD performs the swap; in manual low-power mode it waits there
   // for the trigger to return high, with the spare still powered.
   // The spare always takes over the core named by next_target_r; the
   // released core becomes the new spare, so the rotation covers A, B
   // and C in turn.
   always @* begin
      state_nxt = state_r;
      spare_nxt = spare_r;
      next_target_nxt = next_target_r;
      cnt_nxt = cnt_r;
      case (state_r)
         `ACCS_ST_FG: begin
            if (cnt_r >= cal_length_r) begin
               state_nxt = `ACCS_ST_IDLE;
               cnt_nxt = {CW{1'b0}};
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         `ACCS_ST_IDLE: begin
            cnt_nxt = {CW{1'b0}};
            if (background_calibration_enable & !trigger_source_select &
               software_calibration_request_r) begin // R10
               if (low_power_spare_enable)
                  state_nxt = `ACCS_ST_SLEEP; // R12
               else
                  state_nxt = `ACCS_ST_CAL; // R02
            end else if (!background_calibration_enable & trig_rise) begin
               state_nxt = `ACCS_ST_FG; // R09
            end
         end
         `ACCS_ST_SLEEP: begin
            cnt_nxt = cnt_r + 1'b1;
            if (!background_calibration_enable) begin
               state_nxt = `ACCS_ST_IDLE;
            end else if (!low_power_spare_enable) begin
               state_nxt = `ACCS_ST_CAL;
               cnt_nxt = {CW{1'b0}};
            end else if (manual_swap_control) begin
               if (!trig) begin // R17 R18
                  state_nxt = `ACCS_ST_SETTLE;
                  cnt_nxt = {CW{1'b0}};
               end
            end else if (cnt_r >= spare_sleep_interval_r) begin // R14
               state_nxt = `ACCS_ST_SETTLE; // R13
               cnt_nxt = {CW{1'b0}};
            end
         end
         `ACCS_ST_SETTLE: begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r >= spare_settle_interval_r) begin // R15
               state_nxt = `ACCS_ST_CAL;
               cnt_nxt = {CW{1'b0}};
            end
         end
         `ACCS_ST_CAL: begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r >= cal_length_r) begin
               state_nxt = `ACCS_ST_HOLD;
               cnt_nxt = {CW{1'b0}};
            end
         end
         `ACCS_ST_HOLD: begin
            // Swap allowed unless manual low-power holds it off.
            if (!(low_power_background_mode & manual_swap_control &
               !trig)) begin // R19 R16
               spare_nxt = next_target_r ? core_in_use_b :
                  core_in_use_a; // R11
               next_target_nxt = !next_target_r; // R05
               if (!background_calibration_enable)
                  state_nxt = `ACCS_ST_IDLE;
               else if (low_power_spare_enable)
                  state_nxt = `ACCS_ST_SLEEP; // R16
               else
                  state_nxt = `ACCS_ST_CAL; // R11
            end
         end
         default: state_nxt = `ACCS_ST_IDLE;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= `ACCS_ST_FG; // R07
         spare_r <= `ACCS_CORE_C;
         next_target_r <= 1'b0;
         cnt_r <= {CW{1'b0}};
         fg_done_r <= 1'b0;
         spare_calibration_finished_r <= 1'b0;
         core_in_use_a <= `ACCS_CORE_A;
         core_in_use_b <= `ACCS_CORE_B;
      end else begin
         state_r <= state_nxt;
         spare_r <= spare_nxt;
         next_target_r <= next_target_nxt;
         cnt_r <= cnt_nxt;
         if (state_r == `ACCS_ST_FG)
            fg_done_r <= (state_nxt != `ACCS_ST_FG);
         spare_calibration_finished_r <= (state_nxt == `ACCS_ST_HOLD);
         if (state_r == `ACCS_ST_HOLD && state_nxt != `ACCS_ST_HOLD) begin
            if (next_target_r)
               core_in_use_b <= spare_r; // R05
            else
               core_in_use_a <= spare_r; // R05
         end
      end
   end

   // ==========================================================
   // Bank control and data path
   // ==========================================================
   reg [DW-1:0] core_word [0:2];
   reg [5:0] bank_power_nxt;
   reg [5:0] bank_calibrate_nxt;
   reg [2:0] spare_onehot;
   integer k;
   always @* begin
      // Each core's two banks sample out of phase.
      core_word[0] = bank_phase ? bank_sample_1 : bank_sample_0; // R03
      core_word[1] = bank_phase ? bank_sample_3 : bank_sample_2; // R03
      core_word[2] = bank_phase ? bank_sample_5 : bank_sample_4; // R03
   end

   wire spare_off = (state_r == `ACCS_ST_SLEEP) |
      (state_r == `ACCS_ST_IDLE);
   wire spare_cal = (state_r == `ACCS_ST_CAL);

   // ==========================================================
   // Bank enables
   // ==========================================================
   // Banks 2k and 2k+1 form core k; FG calibrates all six banks, otherwise only
   // the spare core's pair is calibrated or powered down, so serving cores never lose power.
   always @* begin
      bank_power_nxt = `ACCS_BANKS_ALL;
      bank_calibrate_nxt = `ACCS_BANKS_ALL; // R06
      spare_onehot = {3{1'b0}};
      for (k = 0; k < 3; k = k + 1) begin
         spare_onehot[k] = (spare_r == k);
      end
      if (state_r != `ACCS_ST_FG) begin
         for (k = 0; k < 3; k = k + 1) begin
            bank_calibrate_nxt[2*k] = spare_cal & spare_onehot[k]; // R06
            bank_calibrate_nxt[2*k+1] = spare_cal & spare_onehot[k];
            bank_power_nxt[2*k] = !(spare_onehot[k] &
               low_power_background_mode & spare_off); // R12
            bank_power_nxt[2*k+1] = !(spare_onehot[k] &
               low_power_background_mode & spare_off);
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sample_out_a <= `ACCS_MIDCODE;
         sample_out_b <= `ACCS_MIDCODE;
         bank_power <= `ACCS_BANKS_ALL;
         bank_calibrate <= `ACCS_BANKS_ALL;
         core_a_input_b <= 1'b0;
         core_b_input_b <= 1'b1;
         calibration_status_pin <= 1'b0;
      end else begin
         core_a_input_b <= single_channel & input_b_select; // R04
         core_b_input_b <= !single_channel | input_b_select; // R04
         if (state_r == `ACCS_ST_FG) begin
            sample_out_a <= `ACCS_MIDCODE; // R01
            sample_out_b <= `ACCS_MIDCODE; // R01
         end else begin
            sample_out_a <= core_word[core_in_use_a]; // R02
            sample_out_b <= core_word[core_in_use_b]; // R02
         end
         bank_calibrate <= bank_calibrate_nxt; // R06
         bank_power <= bank_power_nxt; // R12
         calibration_status_pin <= status_select ?
            spare_calibration_finished_r : fg_done_r; // R20
      end
   end

endmodule // accs_sequencer

/* File: verification/accs_sequencer_assertions.sv */
// Port-level checks for the calibration sequencer.
`timescale 1ns/1ns
module accs_sequencer_assertions #(
   parameter DW = 12,
   parameter CW = 32
) (
   input wire hclk,
   input wire hresetn,
   input wire single_channel,
   input wire input_b_select,
   input wire [DW-1:0] sample_out_a,
   input wire [DW-1:0] sample_out_b,
   input wire [5:0] bank_power,
   input wire [5:0] bank_calibrate,
   input wire [1:0] core_in_use_a,
   input wire [1:0] core_in_use_b,
   input wire core_a_input_b,
   input wire core_b_input_b
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire [1:0] cal_a = bank_calibrate[2*core_in_use_a +: 2];
   wire [1:0] pwr_a = bank_power[2*core_in_use_a +: 2];
   wire [1:0] pwr_b = bank_power[2*core_in_use_b +: 2];
   sequence s_dual;
      !single_channel ##1 !single_channel;
   endsequence
   sequence s_single_b;
      single_channel && input_b_select ##1 single_channel && input_b_select;
   endsequence
   a_mid_in_cal: assert property (|cal_a |-> sample_out_a == {DW{1'b0}})
      else $error("output a not mid-code while its core calibrates");
   a_reset_cal: assert property ($rose(hresetn) |->
      (sample_out_a == {DW{1'b0}} && sample_out_b == {DW{1'b0}})[*8])
      else $error("no calibration right after reset");
   a_cores_apart: assert property (core_in_use_a != core_in_use_b
      && core_in_use_a != 2'h3 && core_in_use_b != 2'h3)
      else $error("serving cores clash or are out of range");
   a_serving_on: assert property (pwr_a == 2'b11 && pwr_b == 2'b11)
      else $error("a serving core is powered down");
   a_one_swap: assert property ($changed(core_in_use_a) |->
      $stable(core_in_use_b))
      else $error("both outputs swapped at once");
   a_swap_spare: assert property ($changed(core_in_use_a) |->
      core_in_use_a != $past(core_in_use_b))
      else $error("output a took the core of output b");
   a_route_dual: assert property (s_dual |->
      !core_a_input_b && core_b_input_b)
      else $error("dual-channel routing wrong");
   a_route_single: assert property (s_single_b |->
      core_a_input_b && core_b_input_b)
      else $error("single-channel routing wrong");
endmodule // accs_sequencer_assertions

bind accs_sequencer accs_sequencer_assertions #(.DW(DW), .CW(CW))
   u_accs_sequencer_assertions (.hclk, .hresetn, .single_channel,
   .input_b_select, .sample_out_a, .sample_out_b, .bank_power,
   .bank_calibrate, .core_in_use_a, .core_in_use_b, .core_a_input_b,
   .core_b_input_b);

/* File: verification/accs_ctrl_model.sv */
// System controller model: trigger pin driver and ready watch.
`timescale 1ns/1ns
module accs_ctrl_model (
   input wire hclk,
   input wire calibration_status_pin,
   output reg calibration_pin_request
);
   initial calibration_pin_request = 1'b0;
   task set_pin(input bit v);
      begin
         @(posedge hclk);
         calibration_pin_request <= v;
      end
   endtask
   // Holds off programming until power-up calibration reports done.
   task wait_ready(output bit ok);
      integer i;
      begin
         i = 0;
         while (calibration_status_pin !== 1'b1 && i < 1000) begin
            @(posedge hclk);
            i = i + 1;
         end
         ok = (i < 1000);
      end
   endtask
endmodule // accs_ctrl_model

/* File: verification/adc_core_calibration_sequencer_test.sv */
// Self-checking bench for the calibration sequencer.
`timescale 1ns/1ns
`include "accs_defines.vh"
module adc_core_calibration_sequencer_test;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0000_0000;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0000_0000;
   reg single_channel = 1'b0;
   reg input_b_select = 1'b0;
   reg bank_phase = 1'b0;
   reg [7:0] cnt = 8'h00;
   reg [3:0] saved;
   reg [31:0] rd;
   bit ok;
   int n;
   int fail_count = 0;
   int n_compared = 0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, pin, stat, ca, cb;
   wire [11:0] soa, sob;
   wire [5:0] pwr, cal;
   wire [1:0] cua, cub;
   always #10 hclk = ~hclk;
   always @(posedge hclk) begin
      cnt <= cnt + 8'h01;
      bank_phase <= ~bank_phase;
   end
   accs_sequencer u_accs_sequencer (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(1'b1), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .calibration_pin_request(pin), .single_channel(single_channel),
      .input_b_select(input_b_select), .bank_sample_0({4'h1, cnt}),
      .bank_sample_1({4'h2, cnt}), .bank_sample_2({4'h3, cnt}),
      .bank_sample_3({4'h4, cnt}), .bank_sample_4({4'h5, cnt}),
      .bank_sample_5({4'h6, cnt}), .bank_phase(bank_phase),
      .sample_out_a(soa), .sample_out_b(sob), .bank_power(pwr),
      .bank_calibrate(cal), .core_in_use_a(cua), .core_in_use_b(cub),
      .core_a_input_b(ca), .core_b_input_b(cb),
      .calibration_status_pin(stat));
   accs_ctrl_model u_accs_ctrl_model (.hclk(hclk),
      .calibration_status_pin(stat), .calibration_pin_request(pin));
   task print_verdict;
      begin
         if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   function bit cond(input int k);
      case (k)
         0: cond = pwr != 6'h3F;
         1: cond = pwr == 6'h3F && cal == 6'h00;
         2: cond = cal != 6'h00;
         3: cond = soa == 12'h000 && sob == 12'h000;
         4: cond = soa != 12'h000;
         5: cond = cua == 2'h2;
         6: cond = cub == 2'h0;
         default: cond = {cua, cub} != saved;
      endcase
   endfunction
   task wait_for(input int k);
      integer i;
      begin
         i = 0;
         while (!cond(k) && i < 3000) begin
            @(posedge hclk);
            i = i + 1;
         end
         chk(i < 3000, 1);
         if (i == 3000)
            print_verdict;
      end
   endtask
   task span(input int k, input int exp);
      begin
         wait_for(k);
         n = 0;
         while (cond(k) && n < 3000) begin
            @(posedge hclk);
            n = n + 1;
         end
         chk(n, exp);
      end
   endtask
   task ahb(input bit w, input [7:0] a, input [31:0] wd);
      integer t;
      begin
         t = 0;
         hsel <= 1'b1;
         haddr <= {24'h00_0000, a};
         htrans <= 2'h2;
         hwrite <= w;
         @(posedge hclk);
         while (hreadyout !== 1'b1 && t < 100) begin
            @(posedge hclk);
            t = t + 1;
         end
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= wd;
         @(posedge hclk);
         while (hreadyout !== 1'b1 && t < 100) begin
            @(posedge hclk);
            t = t + 1;
         end
         rd = hrdata;
         chk(hresp, 0);
         if (t >= 100) begin
            chk(t, 0);
            print_verdict;
         end
      end
   endtask
   task t_powerup;
      begin
         repeat (5) @(posedge hclk);
         chk(cond(3), 1);
         u_accs_ctrl_model.wait_ready(ok);
         chk(ok, 1);
         if (!ok)
            print_verdict;
         ahb(0, `ACCS_OFF_SLEEP, 32'h0000_0000);
         chk(rd, `ACCS_SLEEP_RESET);
         ahb(0, `ACCS_OFF_SETTLE, 32'h0000_0000);
         chk(rd, `ACCS_SETTLE_RESET);
         ahb(1, 8'h18, 32'hFFFF_FFFF);
         ahb(0, 8'h18, 32'h0000_0000);
         chk(rd, 32'h0000_0000);
         wait_for(4);
         chk({ca, cb}, 2'b01);
         single_channel <= 1'b1;
         input_b_select <= 1'b1;
         repeat (3) @(posedge hclk);
         chk({ca, cb}, 2'b11);
         single_channel <= 1'b0;
         ahb(1, `ACCS_OFF_CALLEN, 32'h0000_0004);
         ahb(1, `ACCS_OFF_SLEEP, 32'h0000_0006);
         ahb(1, `ACCS_OFF_SETTLE, 32'h0000_0003);
      end
   endtask
   task t_fg;
      begin
         ahb(1, `ACCS_OFF_CTRL, 32'h0000_0002);
         u_accs_ctrl_model.set_pin(1'b1);
         wait_for(3);
         wait_for(4);
         u_accs_ctrl_model.set_pin(1'b0);
         ahb(1, `ACCS_OFF_CTRL, 32'h0000_0000);
         ahb(1, `ACCS_OFF_TRIG, 32'h0000_0000);
         ahb(1, `ACCS_OFF_TRIG, 32'h0000_0001);
         wait_for(3);
         wait_for(4);
      end
   endtask
   task t_bg;
      begin
         ahb(1, `ACCS_OFF_TRIG, 32'h0000_0000);
         ahb(1, `ACCS_OFF_CTRL, 32'h0000_0001);
         ahb(1, `ACCS_OFF_TRIG, 32'h0000_0001);
         wait_for(5);
         wait_for(6);
      end
   endtask
   task t_lp_auto;
      begin
         ahb(1, `ACCS_OFF_CTRL, 32'h0000_0005);
         wait_for(0);
         wait_for(1);
         span(1, 4);
         span(2, 5);
         span(0, 7);
         span(1, 4);
      end
   endtask
   task t_lp_manual;
      begin
         ahb(1, `ACCS_OFF_CTRL, 32'h0000_001D);
         repeat (40) @(posedge hclk);
         chk(cond(0), 1);
         saved = {cua, cub};
         ahb(1, `ACCS_OFF_TRIG, 32'h0000_0000);
         span(1, 4);
         span(2, 5);
         repeat (10) @(posedge hclk);
         chk({cua, cub, pwr}, {saved, 6'h3F});
         chk(stat, 1);
         ahb(1, `ACCS_OFF_TRIG, 32'h0000_0001);
         wait_for(7);
      end
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_powerup;
      t_fg;
      t_bg;
      t_lp_auto;
      t_lp_manual;
      print_verdict;
   end
endmodule // adc_core_calibration_sequencer_test
